// ### logic/cvi_defs.vh
// Behaviour
// - with idle-stop clear the interface keeps running while the cpu idles
// - with idle-stop set the interface halts as soon as the cpu idles
// - with internal serial clock the interface stops during sleep
// - with external serial clock it runs in sleep and can wake the cpu
// - wake-up from sleep only when the interrupt enable bit is set
// - with external serial clock, a set interrupt flag during sleep wakes the device when enabled
// - doze mode changes neither operation nor timing
// - unimplemented register bits read as zero
// - transmit words reset to zero, receive words keep contents over reset
// - long words span consecutive buffer registers, one per time slot
// - a dma request is raised on every transfer-complete event
`ifndef CVI_DEFS_VH
`define CVI_DEFS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CVI_OFF_CON1 12'h000
`define CVI_OFF_CON2 12'h004
`define CVI_OFF_CON3 12'h008
`define CVI_OFF_STAT 12'h00C
`define CVI_OFF_TSEN 12'h010
`define CVI_OFF_RSEN 12'h014
`define CVI_OFF_RX0 12'h020
`define CVI_OFF_TX0 12'h030
`define CVI_OFF_IRQ_STAT 12'h040
`define CVI_OFF_IRQ_MASK 12'h044
// ----------------------------------------------------------------
// implemented-bit masks
// ----------------------------------------------------------------
`define CVI_CON1_MASK 16'hAFE3
`define CVI_CON2_MASK 16'h0CEF
`define CVI_CON3_MASK 16'h0FFF
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CVI_EN_BIT 15
`define CVI_SIDL_BIT 13
`define CVI_LOOP_BIT 11
`define CVI_SCKD_BIT 10
`define CVI_SCKE_BIT 9
`define CVI_FSD_BIT 8
`define CVI_UNFM_BIT 7
`define CVI_SDOM_BIT 6
`define CVI_IRQ_DONE 0
`define CVI_IRQ_ROV 1
`define CVI_IRQ_TUNF 2
`define CVI_RST_16 16'h0000
`define CVI_NBUF 4
`define CVI_NIRQ 3
`endif

// ### logic/cvi_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cvi_defs.vh"
module cvi_top #(
  parameter WS_MAX = 16
) (
  // system
  input wire clk,
  input wire rst,
  // power state
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire cpu_doze,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // codec link
  input wire codec_serial_clock_in,
  output reg codec_serial_clock_out,
  output reg codec_serial_clock_oe,
  input wire frame_sync_in,
  output reg frame_sync_out,
  output reg frame_sync_oe,
  input wire serial_data_in,
  output reg serial_data_out,
  // system events
  output reg interface_irq,
  output reg wake_req,
  output reg dma_req
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] con1_q, con2_q, con3_q, tsen_q, rsen_q;
  reg [15:0] txb_q [0:3];
  reg [15:0] rxb_q [0:3];
  reg [`CVI_NIRQ-1:0] irq_stat_q, irq_mask_q;
  reg rov_q, rful_q, tunf_q, tmpty_q;
  reg [3:0] slot_q;
  reg [3:0] bit_q;
  reg [1:0] widx_q;
  reg [15:0] sh_tx_q, sh_rx_q;
  reg [11:0] div_q;
  reg sck_int_q;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sck_s, fs_s, sd_s;
  reg sck_prev_q;
  // two flops per pin before any logic reads it
  always @(posedge clk) begin
    sck_s <= {sck_s[0], codec_serial_clock_in};
  end
  always @(posedge clk) begin
    fs_s <= {fs_s[0], frame_sync_in};
  end
  always @(posedge clk) begin
    sd_s <= {sd_s[0], serial_data_in};
  end
  // edge finder reads only the second stage
  always @(posedge clk) begin
    sck_prev_q <= sck_s[1];
  end
  wire ext_clk = con1_q[`CVI_SCKD_BIT];
  wire enabled = con1_q[`CVI_EN_BIT];
  // doze deliberately unused in gating
  wire halt_idle = cpu_idle & con1_q[`CVI_SIDL_BIT];
  wire halt_sleep = cpu_sleep & ~ext_clk;
  wire run = enabled & ~halt_idle & ~halt_sleep;
  // ----------------------------------------------------------------
  // bit clock: internal divider or external edges
  // ----------------------------------------------------------------
  wire div_hit = (div_q == con3_q[11:0]);
  wire int_rise = run & ~ext_clk & div_hit & ~sck_int_q;
  wire int_fall = run & ~ext_clk & div_hit & sck_int_q;
  // external edges found only from the second sync stage
  wire ext_rise = run & ext_clk & sck_s[1] & ~sck_prev_q;
  wire ext_fall = run & ext_clk & ~sck_s[1] & sck_prev_q;
  wire edge_rise = int_rise | ext_rise;
  wire edge_fall = int_fall | ext_fall;
  wire drive_e = con1_q[`CVI_SCKE_BIT] ? edge_fall : edge_rise;
  wire samp_e = con1_q[`CVI_SCKE_BIT] ? edge_rise : edge_fall;
  wire [3:0] ws = con2_q[3:0];
  wire [3:0] fs_len = con2_q[8:5];
  wire [1:0] blen = con2_q[11:10];
  wire last_bit = (bit_q == ws);
  wire int_fs = (slot_q == 4'h0) & (bit_q == 4'h0);
  wire cur_tx_en = tsen_q[slot_q];
  wire cur_rx_en = rsen_q[slot_q];
  wire word_end = samp_e & last_bit;
  wire done_evt = word_end & (cur_tx_en | cur_rx_en) & (widx_q == blen);
  wire ovf_evt = word_end & cur_rx_en & rful_q;
  wire unf_evt = word_end & cur_tx_en & tmpty_q & (widx_q == blen);
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire [11:0] a = paddr;
  localparam [11:0] RX_BASE = `CVI_OFF_RX0;
  localparam [11:0] TX_BASE = `CVI_OFF_TX0;
  wire rx_hit = (a[11:4] == RX_BASE[11:4]) & (a[1:0] == 2'b00);
  wire tx_hit = (a[11:4] == TX_BASE[11:4]) & (a[1:0] == 2'b00);
  reg [15:0] rdv;
  reg hit;
  always @* begin
    rdv = `CVI_RST_16;
    hit = 1'b1;
    case (a)
      `CVI_OFF_CON1: rdv = con1_q;
      `CVI_OFF_CON2: rdv = con2_q;
      `CVI_OFF_CON3: rdv = con3_q;
      `CVI_OFF_STAT: rdv = {4'h0, slot_q, 4'h0,
        rov_q, rful_q, tunf_q, tmpty_q};
      `CVI_OFF_TSEN: rdv = tsen_q;
      `CVI_OFF_RSEN: rdv = rsen_q;
      `CVI_OFF_IRQ_STAT: rdv = {13'h0000, irq_stat_q};
      `CVI_OFF_IRQ_MASK: rdv = {13'h0000, irq_mask_q};
      default: begin
        if (rx_hit)
          rdv = rxb_q[a[3:2]];
        else if (tx_hit)
          rdv = txb_q[a[3:2]];
        else
          hit = 1'b0;
      end
    endcase
  end
  // bus answer: one wait state
  always @(posedge clk) begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= acc;
  end
  // unmapped addresses are refused
  always @(posedge clk) begin
    if (rst)
      pslverr <= 1'b0;
    else
      pslverr <= acc & ~hit;
  end
  // writes and refused reads return zero
  always @(posedge clk) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (rd)
      prdata <= {16'h0000, rdv};
    else
      prdata <= 32'h0000_0000;
  end
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  wire wr_con1 = wr & (a == `CVI_OFF_CON1);
  wire wr_con2 = wr & (a == `CVI_OFF_CON2);
  wire wr_con3 = wr & (a == `CVI_OFF_CON3);
  wire wr_tsen = wr & (a == `CVI_OFF_TSEN);
  wire wr_rsen = wr & (a == `CVI_OFF_RSEN);
  wire wr_mask = wr & (a == `CVI_OFF_IRQ_MASK);
  // unimplemented bits are masked off on write
  always @(posedge clk) begin
    if (rst)
      con1_q <= `CVI_RST_16;
    else if (wr_con1)
      con1_q <= pwdata[15:0] & `CVI_CON1_MASK;
  end
  always @(posedge clk) begin
    if (rst)
      con2_q <= `CVI_RST_16;
    else if (wr_con2)
      con2_q <= pwdata[15:0] & `CVI_CON2_MASK;
  end
  always @(posedge clk) begin
    if (rst)
      con3_q <= `CVI_RST_16;
    else if (wr_con3)
      con3_q <= pwdata[15:0] & `CVI_CON3_MASK;
  end
  // slot enables: one bit per time slot
  always @(posedge clk) begin
    if (rst)
      tsen_q <= `CVI_RST_16;
    else if (wr_tsen)
      tsen_q <= pwdata[15:0];
  end
  always @(posedge clk) begin
    if (rst)
      rsen_q <= `CVI_RST_16;
    else if (wr_rsen)
      rsen_q <= pwdata[15:0];
  end
  // mask doubles as the wake-up enable
  always @(posedge clk) begin
    if (rst)
      irq_mask_q <= {`CVI_NIRQ{1'b0}};
    else if (wr_mask)
      irq_mask_q <= pwdata[`CVI_NIRQ-1:0];
  end
  // ----------------------------------------------------------------
  // buffers: transmit resets, receive keeps contents
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CVI_NBUF; gi = gi + 1) begin : g_buf
      always @(posedge clk) begin
        if (rst)
          txb_q[gi] <= `CVI_RST_16;
        else if (wr & tx_hit & (a[3:2] == gi))
          txb_q[gi] <= pwdata[15:0];
      end
      // no reset on purpose
      always @(posedge clk) begin
        if (word_end & cur_rx_en & (widx_q == gi))
          rxb_q[gi] <= con1_q[`CVI_LOOP_BIT] ? sh_tx_q : sh_rx_q;
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  wire tx_wr = wr & tx_hit;
  wire rx_rd = rd & rx_hit;
  wire fs_in_start = con1_q[`CVI_FSD_BIT] & sck_s[1] & fs_s[1];
  always @(posedge clk) begin
    if (rst) begin
      slot_q <= 4'h0;
      bit_q <= 4'h0;
      widx_q <= 2'b00;
      sh_tx_q <= `CVI_RST_16;
      sh_rx_q <= `CVI_RST_16;
    end else if (!enabled) begin
      slot_q <= 4'h0;
      bit_q <= 4'h0;
      widx_q <= 2'b00;
    end else begin
      if (samp_e)
        sh_rx_q <= {sh_rx_q[14:0], sd_s[1]};
      if (drive_e & (bit_q == 4'h0))
        sh_tx_q <= txb_q[widx_q];
      else if (drive_e)
        sh_tx_q <= {sh_tx_q[14:0], 1'b0};
      if (word_end) begin
        bit_q <= 4'h0;
        if (cur_tx_en | cur_rx_en)
          widx_q <= (widx_q == blen) ? 2'b00 : widx_q + 2'b01;
        if (slot_q == fs_len | fs_in_start)
          slot_q <= 4'h0;
        else
          slot_q <= slot_q + 4'h1;
      end else if (samp_e)
        bit_q <= bit_q + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // internal bit clock divider
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst)
      div_q <= 12'h000;
    else if (~run | div_hit)
      div_q <= 12'h000;
    else
      div_q <= div_q + 12'h001;
  end
  // frozen whenever run is low, so sleep stops the pin
  always @(posedge clk) begin
    if (rst)
      sck_int_q <= 1'b0;
    else if (int_rise | int_fall)
      sck_int_q <= ~sck_int_q;
  end
  // ----------------------------------------------------------------
  // status flags: set wins over clear, all reset to zero
  // ----------------------------------------------------------------
  // cleared by any receive read
  always @(posedge clk) begin
    if (rst)
      rful_q <= 1'b0;
    else
      rful_q <= done_evt | (rful_q & ~rx_rd);
  end
  // cleared by writing the status register
  always @(posedge clk) begin
    if (rst)
      rov_q <= 1'b0;
    else
      rov_q <= ovf_evt | (rov_q & ~(wr & (a == `CVI_OFF_STAT)));
  end
  // cleared by any transmit write
  always @(posedge clk) begin
    if (rst)
      tmpty_q <= 1'b0;
    else
      tmpty_q <= done_evt | (tmpty_q & ~tx_wr);
  end
  always @(posedge clk) begin
    if (rst)
      tunf_q <= 1'b0;
    else
      tunf_q <= unf_evt | (tunf_q & ~tx_wr);
  end
  // ----------------------------------------------------------------
  // interrupts, wake-up and dma
  // ----------------------------------------------------------------
  wire [`CVI_NIRQ-1:0] evts = {unf_evt, ovf_evt, done_evt};
  wire [`CVI_NIRQ-1:0] w1c =
    (wr & (a == `CVI_OFF_IRQ_STAT)) ? pwdata[`CVI_NIRQ-1:0] : 3'b000;
  // next status: a new event beats a clear in the same cycle
  wire [`CVI_NIRQ-1:0] stat_d = evts | (irq_stat_q & ~w1c);
  wire pending = |(stat_d & irq_mask_q);
  always @(posedge clk) begin
    if (rst)
      irq_stat_q <= {`CVI_NIRQ{1'b0}};
    else
      irq_stat_q <= stat_d;
  end
  // level output, high while an unmasked bit is set
  always @(posedge clk) begin
    if (rst)
      interface_irq <= 1'b0;
    else
      interface_irq <= pending;
  end
  // wake only from sleep on the external clock, when enabled
  always @(posedge clk) begin
    if (rst)
      wake_req <= 1'b0;
    else
      wake_req <= cpu_sleep & ext_clk & pending;
  end
  // one pulse per transfer-complete event
  always @(posedge clk) begin
    if (rst)
      dma_req <= 1'b0;
    else
      dma_req <= done_evt;
  end
  // ----------------------------------------------------------------
  // link pins
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst)
      codec_serial_clock_out <= 1'b0;
    else
      codec_serial_clock_out <= sck_int_q;
  end
  // pin released when the codec supplies the clock
  always @(posedge clk) begin
    if (rst)
      codec_serial_clock_oe <= 1'b0;
    else
      codec_serial_clock_oe <= enabled & ~ext_clk;
  end
  always @(posedge clk) begin
    if (rst)
      frame_sync_out <= 1'b0;
    else
      frame_sync_out <= run & int_fs & ~con1_q[`CVI_FSD_BIT];
  end
  always @(posedge clk) begin
    if (rst)
      frame_sync_oe <= 1'b0;
    else
      frame_sync_oe <= enabled & ~con1_q[`CVI_FSD_BIT];
  end
  // disabled slots send zero
  always @(posedge clk) begin
    if (rst)
      serial_data_out <= 1'b0;
    else
      serial_data_out <= cur_tx_en ? sh_tx_q[15] : 1'b0;
  end
endmodule // cvi_top
`default_nettype wire

// ### tb/cvi_codec.sv
`timescale 1ns/1ps
`default_nettype none
module cvi_codec (
  // control
  input wire logic run,
  input wire logic [15:0] word,
  // link
  output logic sck,
  output logic fs,
  output logic sdo
);
  // clock only within frames, one slot per frame
  initial begin
    sck = 1'b0;
    fs = 1'b0;
    sdo = 1'b0;
    forever begin
      wait (run === 1'b1);
      for (int i = 0; i < 16; i++) begin
        fs = (i == 0);
        sdo = word[15 - i];
        #160 sck = 1'b1;
        #160 sck = 1'b0;
      end
      sdo = ~sdo;
    end
  end
endmodule // cvi_codec
`default_nettype wire

// ### tb/cvi_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cvi_top_sva (
  // system
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_sleep,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // events
  input wire logic codec_serial_clock_oe,
  input wire logic interface_irq,
  input wire logic wake_req,
  input wire logic dma_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_refused_zero: assert property (pready && pslverr |-> prdata == 0)
    else $error("refused read not zero");
  a_wake_sleep: assert property (wake_req |-> $past(cpu_sleep))
    else $error("wake outside sleep");
  a_wake_enable: assert property (wake_req |-> interface_irq)
    else $error("wake without enabled flag");
  a_wake_ext: assert property (wake_req |-> !codec_serial_clock_oe)
    else $error("wake with internal clock");
  a_dma_pulse: assert property ($rose(dma_req) |=> !dma_req)
    else $error("dma request too long");
  c_wake: cover property (wake_req);
  c_dma: cover property (dma_req);
  c_refused: cover property (pready && pslverr);
endmodule // cvi_top_sva
bind cvi_top cvi_top_sva i_sva (.clk, .rst, .cpu_sleep, .psel, .penable,
  .pready, .pslverr, .prdata, .codec_serial_clock_oe, .interface_irq,
  .wake_req, .dma_req);
`default_nettype wire

// ### tb/tb_cvi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cvi_defs.vh"
module tb_cvi_top;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [15:0] d;
    logic [15:0] x;
  } cvi_row_t;
  logic clk, rst, cpu_idle, cpu_sleep, cpu_doze, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, hit, sck, fs, sdi, run, sck_prev;
  logic sck_out, sck_oe, fs_out, fs_oe, sdo, irq, wake, dma;
  logic [15:0] keep;
  int errors = 0, check_count = 0, dma_count = 0, toggles = 0, t0;
  cvi_row_t rows [14];
  cvi_top i_cvi_top (.clk(clk), .rst(rst), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .cpu_doze(cpu_doze), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .codec_serial_clock_in(sck), .codec_serial_clock_out(sck_out),
    .codec_serial_clock_oe(sck_oe), .frame_sync_in(fs),
    .frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .serial_data_in(sdi),
    .serial_data_out(sdo), .interface_irq(irq), .wake_req(wake),
    .dma_req(dma));
  cvi_codec i_cvi_codec (.run(run), .word(16'hA5C3), .sck(sck), .fs(fs),
    .sdo(sdi));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    sck_prev <= sck_out;
    if (dma === 1'b1) dma_count <= dma_count + 1;
    if (cpu_sleep === 1'b1 && sck_out !== sck_prev) toggles <= toggles + 1;
  end
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll;
    hit = 1'b0;
    repeat (500) if (hit !== 1'b1) begin
      apb(1'b0, `CVI_OFF_IRQ_STAT, 32'h0000_0000);
      hit = rd[`CVI_IRQ_DONE];
    end
  endtask
  task automatic wr_wait(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
    repeat (3) @(posedge clk);
  endtask
  task summarize;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    summarize;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst, cpu_idle, cpu_sleep, cpu_doze, psel, penable, pwrite} = 7'h40;
    {paddr, pwdata, run} = 0;
    rows = '{'{12'h000, 0, 0, 0}, '{12'h004, 0, 0, 0}, '{12'h008, 0, 0, 0},
      '{12'h00C, 0, 0, 0}, '{12'h010, 0, 0, 0}, '{12'h014, 0, 0, 0},
      '{12'h030, 0, 0, 0}, '{12'h03C, 0, 0, 0}, '{12'h044, 0, 0, 0},
      '{12'h000, 1, 16'hFFFF, 16'hAFE3}, '{12'h004, 1, 16'hFFFF, 16'h0CEF},
      '{12'h008, 1, 16'hFFFF, 16'h0FFF}, '{12'h014, 1, 16'hFFFF, 16'hFFFF},
      '{12'h034, 1, 16'hBEEF, 16'hBEEF}};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, {16'hFFFF, rows[i].d});
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("register", {16'h0000, rows[i].x}, rd);
    end
    apb(1'b1, 12'h0FC, 32'h0000_FFFF);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped", 32'h8000_0000, {err, rd[30:0] | rd[31]});
    wr_wait(`CVI_OFF_CON2, 16'h000F);
    wr_wait(`CVI_OFF_TSEN, 16'h0001);
    wr_wait(`CVI_OFF_TX0, 16'hA5C3);
    wr_wait(`CVI_OFF_CON1, 16'h8500);
    chk("pins released", 0, {sck_oe, fs_oe});
    cpu_doze <= 1'b1;
    run <= 1'b1;
    poll;
    chk("done in doze", 1, hit);
    chk("dma seen", 1, dma_count > 0);
    wr_wait(`CVI_OFF_IRQ_MASK, 16'h0001);
    chk("irq on", 1, irq);
    cpu_sleep <= 1'b1;
    wr_wait(`CVI_OFF_IRQ_MASK, 16'h0001);
    chk("wake on", 1, wake);
    wr_wait(`CVI_OFF_IRQ_MASK, 16'h0000);
    chk("wake masked", 0, {irq, wake});
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    wr_wait(`CVI_OFF_IRQ_STAT, 16'h0001);
    poll;
    chk("idle runs", 1, hit);
    wr_wait(`CVI_OFF_CON1, 16'hA500);
    wr_wait(`CVI_OFF_IRQ_STAT, 16'h0007);
    poll;
    chk("idle halts", 0, hit);
    {cpu_idle, run} <= 2'b00;
    wr_wait(`CVI_OFF_CON1, 16'h8000);
    wr_wait(`CVI_OFF_CON3, 16'h0001);
    chk("pins driven", 32'h0000_0003, {sck_oe, fs_oe});
    cpu_sleep <= 1'b1;
    repeat (5) @(posedge clk);
    t0 = toggles;
    repeat (200) @(posedge clk);
    chk("sleep clock", 0, toggles - t0);
    cpu_sleep <= 1'b0;
    apb(1'b0, `CVI_OFF_RX0, 32'h0000_0000);
    keep = rd[15:0];
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CVI_OFF_RX0, 32'h0000_0000);
    chk("rx kept", {16'h0000, keep}, rd);
    apb(1'b0, `CVI_OFF_TX0, 32'h0000_0000);
    chk("tx cleared", 0, rd);
    summarize;
  end
endmodule // tb_cvi_top
`default_nettype wire
